// >>> bench/pin_source_model.sv
// external pin sources: counter clock pins and capture pins
module pin_source_model (
  input  wire logic  pclk,
  output logic       ext_clk_pin,
  output logic       fixed_clk,
  output logic [1:0] chan_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_clk_pin = 1'b0;
    fixed_clk = 1'b0;
    chan_pin = 2'h0;
  end
  // pulses run at an eighth of the bus rate
  task automatic pulses(input logic sel, input int n);
    repeat (n) begin
      repeat (4) @(posedge pclk);
      if (sel) fixed_clk <= 1'b1;
      else ext_clk_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      if (sel) fixed_clk <= 1'b0;
      else ext_clk_pin <= 1'b0;
    end
  endtask : pulses
  // capture pins never carry the counter clock
  task automatic set_pin(input logic c, input logic v);
    @(posedge pclk);
    chan_pin[c] <= v;
    repeat (8) @(posedge pclk);
  endtask : set_pin
endmodule : pin_source_model

// >>> bench/timer_capture_props.sv
// checker for bus answers, control readback, pin ownership and request gating
module timer_capture_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        wrap_irq,
  input wire logic [1:0]  chan_irq,
  input wire logic [1:0]  chan_pin_owned
);
  logic [6:0] sc_sh;
  logic [4:0] ch_sh [2];
  logic [1:0] own_sh;
  logic [1:0] ie_sh;
  wire        wr     = psel && penable && pready && pwrite;
  wire        rd     = psel && penable && pready && !pwrite;
  wire        ch_hit = paddr[11:5] == 7'h01 && paddr[3:0] == 4'h0;
  assign own_sh = {|ch_sh[1][1:0], |ch_sh[0][1:0]};
  assign ie_sh  = {ch_sh[1][4], ch_sh[0][4]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_sh <= 7'h00;
      ch_sh <= '{5'h00, 5'h00};
    end else begin
      if (wr && paddr == 12'h000) sc_sh <= pwdata[6:0];
      if (wr && ch_hit) ch_sh[paddr[4]] <= pwdata[6:2];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_quiet: assert property (
    $rose(presetn) |-> !wrap_irq && chan_irq == 2'h0 && chan_pin_owned == 2'h0)
    else $error("outputs not idle after reset");
  a_status_back: assert property (
    rd && paddr == 12'h000 |-> prdata[6:0] == sc_sh)
    else $error("status readback wrong");
  a_chan_back: assert property (
    rd && ch_hit |-> prdata[6:2] == ch_sh[paddr[4]])
    else $error("channel control readback wrong");
  a_owned_edge: assert property (
    $stable(own_sh) [*2] |-> chan_pin_owned == own_sh)
    else $error("pin ownership wrong");
  a_wrap_gate: assert property (
    wrap_irq |-> $past(sc_sh[6]))
    else $error("wrap request without enable");
  a_chan_gate: assert property (
    (chan_irq & ~$past(ie_sh)) == 2'h0)
    else $error("channel request without enable");
  a_ready_time: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer timing wrong");
  a_byte_wide: assert property (
    rd |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
endmodule : timer_capture_props

bind timer_counter_input_capture timer_capture_props u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .wrap_irq, .chan_irq, .chan_pin_owned);

// >>> bench/timer_counter_input_capture_bench.sv
// self-checking bench for the timer with input capture
module timer_counter_input_capture_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, loop_engaged, debug_halt_mode;
  logic [11:0] paddr, ca;
  logic [31:0] pwdata, prdata, lfsr;
  logic        pready, pslverr, ext_clk_pin, fixed_clk, wrap_irq;
  logic [1:0]  chan_pin, chan_irq, chan_pin_owned;
  logic [7:0]  sc;
  logic [8:0]  expq [$];
  int          miscompares, compares, cycles;

  timer_counter_input_capture dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_clk_pin, .fixed_clk, .loop_engaged,
    .debug_halt_mode, .chan_pin, .wrap_irq, .chan_irq, .chan_pin_owned);
  pin_source_model src (.pclk, .ext_clk_pin, .fixed_clk, .chan_pin);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {lfsr[31:8], d};
    lfsr = lfsr_next(lfsr);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [8:0] exp);
    expq.push_back(exp);
    xfer(1'b0, a, 8'h00);
  endtask : rd

  // clear, count n bus edges (or p pin pulses), stop, then check status and count
  task automatic run(input logic [7:0] ctl, t, input int n, p, input logic [15:0] cnt,
                     input logic fl);
    wr(12'h010, t);
    wr(12'h00c, 8'h00);
    wr(12'h004, lfsr[7:0]);
    wr(12'h000, ctl);
    if (p > 0) src.pulses(~ctl[3], p);
    repeat (n - 4) @(posedge pclk);
    wr(12'h000, ctl & 8'he7);
    rd(12'h000, {1'b0, fl, ctl[6:0] & 7'h67});
    rd(12'h008, {1'b0, cnt[7:0]});
    rd(12'h004, {1'b0, cnt[15:8]});
    if (fl) begin
      wr(12'h000, 8'h40);
      repeat (2) @(posedge pclk);
      chk({8'h00, wrap_irq}, 9'h001);
      wr(12'h000, 8'hc0);
      repeat (2) @(posedge pclk);
      chk({8'h00, wrap_irq}, 9'h000);
      wr(12'h000, 8'h00);
    end
  endtask : run

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() == 0) chk(9'h1ff, 9'h000);
      else chk({pslverr, prdata[7:0]}, expq.pop_front());
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    loop_engaged = 1'b0;
    debug_halt_mode = 1'b0;
    lfsr = 32'h01f4;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 9'h000);
    rd(12'h020, 9'h000);
    rd(12'h030, 9'h000);
    rd(12'h014, 9'h100);
    wr(12'h044, 8'hff);
    run(8'h08, 8'h00, 65537, 0, 16'h0001, 1'b1);
    run(8'h08, 8'h05, 20, 0, 16'h0002, 1'b1);
    run(8'h28, 8'h05, 5, 0, 16'h0005, 1'b0);
    run(8'h28, 8'h05, 6, 0, 16'h0004, 1'b1);
    run(8'h0a, 8'h05, 23, 0, 16'h0005, 1'b0);
    run(8'h10, 8'h00, 30, 0, 16'h001e, 1'b0);
    run(8'h00, 8'h00, 20, 0, 16'h0000, 1'b0);
    run(8'h08, 8'h00, 4 + lfsr[4:0], 0, 16'(4 + lfsr[4:0]), 1'b0);
    run(8'h18, 8'h00, 14, 7, 16'h0007, 1'b0);
    loop_engaged <= 1'b1;
    run(8'h10, 8'h00, 14, 7, 16'h0007, 1'b0);
    for (int e = 1; e < 4; e++) begin
      ca = e[0] ? 12'h030 : 12'h020;
      sc = 8'h40 | 8'(e << 2);
      run(8'h08, 8'h00, 5 + e, 0, 16'(5 + e), 1'b0);
      wr(ca, sc);
      src.set_pin(e[0], 1'b1);
      run(8'h08, 8'h00, 20 + e, 0, 16'(20 + e), 1'b0);
      debug_halt_mode <= (e == 3);
      src.set_pin(e[0], 1'b0);
      debug_halt_mode <= 1'b0;
      wr(ca + 12'h008, 8'h5a);
      rd(ca, {1'b0, 8'h80 | sc});
      rd(ca + 12'h008, {1'b0, e == 1 ? 8'h06 : 8'(20 + e)});
      rd(ca + 12'h004, 9'h000);
      chk({7'h00, chan_irq}, e[0] ? 9'h002 : 9'h001);
      chk({7'h00, chan_pin_owned}, e[0] ? 9'h002 : 9'h001);
      wr(ca, 8'h80);
    end
    wr(12'h020, 8'h0c);
    run(8'h08, 8'h00, 260, 0, 16'h0104, 1'b0);
    src.set_pin(1'b0, 1'b1);
    rd(12'h028, 9'h004);
    run(8'h08, 8'h00, 6, 0, 16'h0006, 1'b0);
    src.set_pin(1'b0, 1'b0);
    rd(12'h024, 9'h001);
    rd(12'h028, 9'h006);
    wr(12'h000, 8'h4a);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 9'h000);
    rd(12'h020, 9'h000);
    repeat (4) @(posedge pclk);
    stop_test();
  end
endmodule : timer_counter_input_capture_bench

// >>> design/pin_sync_edge.sv
// three-stage pin synchroniser with agreement filter and edge pulses
module pin_sync_edge (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   pin,
  sync_edge_if.src    e
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic stable_r;
  logic rise_r;
  logic fall_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_r <= 1'b0;
      rise_r   <= 1'b0;
      fall_r   <= 1'b0;
    end else begin
      rise_r <= (s2_r == s3_r) && s3_r && !stable_r;
      fall_r <= (s2_r == s3_r) && !s3_r && stable_r;
      if (s2_r == s3_r) begin
        stable_r <= s3_r;
      end
    end
  end

  assign e.level = stable_r;
  assign e.rise  = rise_r;
  assign e.fall  = fall_r;
endmodule : pin_sync_edge

// >>> design/sync_edge_if.sv
// synchronised pin level and edge pulses
interface sync_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : sync_edge_if

// >>> design/timer_capture_pkg.sv
// types shared by the timer design files
package timer_capture_pkg;

  typedef enum logic [1:0] {
    CLK_OFF   = 2'b00,
    CLK_BUS   = 2'b01,
    CLK_FIXED = 2'b10,
    CLK_EXT   = 2'b11
  } clk_src_t;

  typedef enum logic [1:0] {
    EDGE_RELEASED = 2'b00,
    EDGE_RISE     = 2'b01,
    EDGE_FALL     = 2'b10,
    EDGE_BOTH     = 2'b11
  } edge_sel_t;

endpackage : timer_capture_pkg

// >>> design/timer_capture_regs.svh
// register offsets, field positions and constant values of the timer
`ifndef TIMER_CAPTURE_REGS_SVH
`define TIMER_CAPTURE_REGS_SVH

`define NUM_CHANNELS      2
`define ADDR_W            12

`define OFS_STATUS_CONTROL 12'h000
`define OFS_COUNT_HIGH     12'h004
`define OFS_COUNT_LOW      12'h008
`define OFS_TERM_HIGH      12'h00c
`define OFS_TERM_LOW       12'h010
`define OFS_CHAN_BASE      12'h020
`define OFS_CHAN_END       12'h040
`define SUB_CHAN_SC        4'h0
`define SUB_CHAN_VH        4'h4
`define SUB_CHAN_VL        4'h8
`define CH_IDX_BIT         4
`define CH_SUB_HI          3

`define SC_FLAG_BIT        7
`define SC_IRQEN_BIT       6
`define SC_CPWM_BIT        5
`define SC_CLKS_HI         4
`define SC_CLKS_LO         3
`define SC_PS_HI           2
`define SC_PS_LO           0

`define CH_FLAG_BIT        7
`define CH_IRQEN_BIT       6
`define CH_MODE_HI         5
`define CH_MODE_LO         4
`define CH_EDGE_HI         3
`define CH_EDGE_LO         2

`define BYTE_HI            7
`define MODE_CAPTURE       2'h0
`define COUNT_ZERO         16'h0000
`define COUNT_ONE          16'h0001
`define COUNT_ALL_ONES     16'hffff
`define PRE_ONE            7'h01
`define PRE_ZERO           7'h00
`define DATA_ZERO          32'h0000_0000

`endif

// >>> design/timer_counter_input_capture.sv
// 16-bit timer counter with prescaler, wrap flag and input capture channels on apb
//
// Function
// RQ1 - clock source field picks off, bus clock, fixed clock or external pin
// RQ2 - reset clears the clock source field so the timer is idle
// RQ3 - source field always read/write; stopping keeps counter and registers
// RQ4 - external clock is synchronised on the bus clock; source at most quarter rate
// RQ5 - fixed clock equals bus clock unless a loop is engaged, then synchronised
// RQ6 - center pwm select forces all channels to center pwm and up/down counting; here it selects up/down counting and stops capture on all channels, with no pwm
// RQ7 - wrap interrupt is a level while wrap flag and its enable are both set
// RQ8 - free up count runs zero to all ones, wraps and sets wrap flag
// RQ9 - with a modulus the up count returns to zero after it, setting wrap flag
// RQ10 - up/down count goes zero to terminal and back, ends lasting one step
// RQ11 - up/down mode sets wrap flag when leaving the terminal count downward
// RQ12 - writing either counter byte clears the counter and its read latch
// RQ13 - without center pwm two mode bits choose each channel's function
// RQ14 - active pin edge copies the counter into the channel value register
// RQ15 - channel value bytes ignore writes while in capture mode
// RQ16 - byte reads of a capture are coherent; status write resets the latch
// RQ17 - each capture sets the channel flag, raising interrupt when enabled
// RQ18 - capture still works in debug halt using the frozen counter
// RQ19 - software must not capture on a pin that also feeds the external clock
// RQ20 - edge field: rising, falling, both, or zero releases the pin
// RQ21 - reset clears control, center select and channel mode and edge bits
// RQ22 - selected clock passes a programmable prescaler that steps the counter
`include "timer_capture_regs.svh"
module timer_counter_input_capture (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [`ADDR_W-1:0]           paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         ext_clk_pin,
  input  wire logic                         fixed_clk,
  input  wire logic                         loop_engaged,
  input  wire logic                         debug_halt_mode,
  input  wire logic [`NUM_CHANNELS-1:0]     chan_pin,
  output logic                              wrap_irq,
  output logic      [`NUM_CHANNELS-1:0]     chan_irq,
  output logic      [`NUM_CHANNELS-1:0]     chan_pin_owned
);
  localparam int NCH = `NUM_CHANNELS;

  timer_capture_pkg::clk_src_t clk_src_r;
  logic [2:0]                  prescale_r;
  logic                        cpwm_r, wrap_irq_en_r, wrap_flag_r, count_down_r;
  logic                        cnt_lat_r, cnt_lat_hi_r, pready_r, pslverr_r, wrap_irq_r;
  logic [15:0]                 count_r, term_r, cnt_buf_r;
  logic [6:0]                  pre_cnt_r;
  logic [31:0]                 prdata_r;
  logic [NCH-1:0]              chan_irq_r, pin_owned_r;
  logic                        acc_wr, rd_go, unmapped, tick, step, down_nxt, wrap_set, cnt_wr;
  logic                        hit_sc, hit_cnt_h, hit_cnt_l, hit_term_h, hit_term_l;
  logic                        hit_ch_sc, hit_ch_vh, hit_ch_vl;
  logic [`ADDR_W-1:0]          ch_off;
  logic [0:0]                  ch_idx;
  logic [31:0]                 rd_data;
  logic [6:0]                  pre_mask;
  logic [15:0]                 term, count_nxt;
  logic                        ch_flag_w  [NCH];
  logic                        ch_irqen_w [NCH];
  logic [1:0]                  ch_edge_w  [NCH];
  logic [7:0]                  ch_sc_rd   [NCH];
  logic [7:0]                  ch_rd_hi   [NCH];
  logic [7:0]                  ch_rd_lo   [NCH];
  sync_edge_if ext_e ();
  sync_edge_if fix_e ();

  pin_sync_edge u_ext_sync (.pclk(pclk), .presetn(presetn), .pin(ext_clk_pin), .e(ext_e));
  pin_sync_edge u_fix_sync (.pclk(pclk), .presetn(presetn), .pin(fixed_clk), .e(fix_e));

  assign acc_wr = psel && penable && pready_r && pwrite;
  assign rd_go  = psel && penable && !pready_r && !pwrite;
  assign cnt_wr = acc_wr && (hit_cnt_h || hit_cnt_l);

  // address decode
  always_comb begin
    hit_sc     = 1'b0;
    hit_cnt_h  = 1'b0;
    hit_cnt_l  = 1'b0;
    hit_term_h = 1'b0;
    hit_term_l = 1'b0;
    hit_ch_sc  = 1'b0;
    hit_ch_vh  = 1'b0;
    hit_ch_vl  = 1'b0;
    unmapped   = 1'b0;
    ch_off     = paddr - `OFS_CHAN_BASE;
    ch_idx     = ch_off[`CH_IDX_BIT];
    if (paddr == `OFS_STATUS_CONTROL) begin
      hit_sc = 1'b1;
    end else if (paddr == `OFS_COUNT_HIGH) begin
      hit_cnt_h = 1'b1;
    end else if (paddr == `OFS_COUNT_LOW) begin
      hit_cnt_l = 1'b1;
    end else if (paddr == `OFS_TERM_HIGH) begin
      hit_term_h = 1'b1;
    end else if (paddr == `OFS_TERM_LOW) begin
      hit_term_l = 1'b1;
    end else if (paddr >= `OFS_CHAN_BASE && paddr < `OFS_CHAN_END &&
                 ch_off[`CH_SUB_HI:0] == `SUB_CHAN_SC) begin
      hit_ch_sc = 1'b1;
    end else if (paddr >= `OFS_CHAN_BASE && paddr < `OFS_CHAN_END &&
                 ch_off[`CH_SUB_HI:0] == `SUB_CHAN_VH) begin
      hit_ch_vh = 1'b1;
    end else if (paddr >= `OFS_CHAN_BASE && paddr < `OFS_CHAN_END &&
                 ch_off[`CH_SUB_HI:0] == `SUB_CHAN_VL) begin
      hit_ch_vl = 1'b1;
    end else begin
      unmapped = 1'b1;
    end
  end

  // read data mux
  always_comb begin
    rd_data = `DATA_ZERO;
    if (hit_sc) begin
      rd_data[`SC_FLAG_BIT]              = wrap_flag_r;
      rd_data[`SC_IRQEN_BIT]             = wrap_irq_en_r;
      rd_data[`SC_CPWM_BIT]              = cpwm_r;
      rd_data[`SC_CLKS_HI:`SC_CLKS_LO]   = clk_src_r;
      rd_data[`SC_PS_HI:`SC_PS_LO]       = prescale_r;
    end else if (hit_cnt_h) begin
      rd_data[`BYTE_HI:0] = (cnt_lat_r && !debug_halt_mode) ? cnt_buf_r[15:8] : count_r[15:8];
    end else if (hit_cnt_l) begin
      rd_data[`BYTE_HI:0] = (cnt_lat_r && !debug_halt_mode) ? cnt_buf_r[7:0] : count_r[7:0];
    end else if (hit_term_h) begin
      rd_data[`BYTE_HI:0] = term_r[15:8];
    end else if (hit_term_l) begin
      rd_data[`BYTE_HI:0] = term_r[7:0];
    end else if (hit_ch_sc) begin
      rd_data[`BYTE_HI:0] = ch_sc_rd[ch_idx];
    end else if (hit_ch_vh) begin
      rd_data[`BYTE_HI:0] = ch_rd_hi[ch_idx];
    end else if (hit_ch_vl) begin
      rd_data[`BYTE_HI:0] = ch_rd_lo[ch_idx];
    end
  end

  // apb slave handshake, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= `DATA_ZERO;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= psel && penable && !pready_r;
      if (psel && penable && !pready_r) begin
        prdata_r  <= pwrite ? `DATA_ZERO : rd_data;
        pslverr_r <= unmapped;
      end
    end
  end

  // main control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_src_r     <= timer_capture_pkg::CLK_OFF; // RQ2
      prescale_r    <= 3'h0; // RQ21
      cpwm_r        <= 1'b0; // RQ21
      wrap_irq_en_r <= 1'b0; // RQ21
    end else if (acc_wr && hit_sc) begin
      clk_src_r     <= timer_capture_pkg::clk_src_t'(pwdata[`SC_CLKS_HI:`SC_CLKS_LO]); // RQ3
      prescale_r    <= pwdata[`SC_PS_HI:`SC_PS_LO];
      cpwm_r        <= pwdata[`SC_CPWM_BIT];
      wrap_irq_en_r <= pwdata[`SC_IRQEN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_r <= `COUNT_ZERO;
    end else if (acc_wr && hit_term_h) begin
      term_r[15:8] <= pwdata[`BYTE_HI:0];
    end else if (acc_wr && hit_term_l) begin
      term_r[7:0] <= pwdata[`BYTE_HI:0];
    end
  end

  // clock source selection and prescaler
  always_comb begin
    case (clk_src_r)
      timer_capture_pkg::CLK_OFF:   tick = 1'b0; // RQ1
      timer_capture_pkg::CLK_BUS:   tick = 1'b1; // RQ1
      timer_capture_pkg::CLK_FIXED: tick = loop_engaged ? fix_e.rise : 1'b1; // RQ5
      default:                      tick = ext_e.rise; // RQ4
    endcase
  end

  assign pre_mask = 7'((8'h01 << prescale_r) - 8'h01);
  assign step     = tick && !debug_halt_mode && ((pre_cnt_r & pre_mask) == pre_mask); // RQ22

  // counting modes
  always_comb begin
    term      = (term_r == `COUNT_ZERO) ? `COUNT_ALL_ONES : term_r;
    count_nxt = count_r + `COUNT_ONE;
    down_nxt  = count_down_r;
    wrap_set  = 1'b0;
    if (cpwm_r) begin // RQ6
      if (!count_down_r) begin
        if (count_r >= term) begin
          count_nxt = count_r - `COUNT_ONE; // RQ10
          down_nxt  = 1'b1;
          wrap_set  = step; // RQ11
        end
      end else if (count_r == `COUNT_ZERO) begin
        down_nxt = 1'b0; // RQ10
      end else begin
        count_nxt = count_r - `COUNT_ONE;
      end
    end else begin
      down_nxt = 1'b0;
      if (count_r == term || count_r == `COUNT_ALL_ONES) begin
        count_nxt = `COUNT_ZERO; // RQ8 RQ9
        wrap_set  = step; // RQ8 RQ9
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r      <= `COUNT_ZERO;
      count_down_r <= 1'b0;
      pre_cnt_r    <= `PRE_ZERO;
    end else if (cnt_wr) begin
      count_r      <= `COUNT_ZERO; // RQ12
      count_down_r <= 1'b0;
      pre_cnt_r    <= `PRE_ZERO;
    end else if (tick && !debug_halt_mode) begin
      pre_cnt_r <= pre_cnt_r + `PRE_ONE; // RQ22
      if (step) begin
        count_r      <= count_nxt;
        count_down_r <= down_nxt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_flag_r <= 1'b0;
    end else if (wrap_set) begin
      wrap_flag_r <= 1'b1;
    end else if (acc_wr && hit_sc && pwdata[`SC_FLAG_BIT]) begin
      wrap_flag_r <= 1'b0;
    end
  end

  // counter read coherency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_lat_r    <= 1'b0;
      cnt_lat_hi_r <= 1'b0;
      cnt_buf_r    <= `COUNT_ZERO;
    end else if (cnt_wr) begin
      cnt_lat_r <= 1'b0; // RQ12
    end else if (rd_go && (hit_cnt_h || hit_cnt_l) && !debug_halt_mode) begin
      if (!cnt_lat_r) begin
        cnt_lat_r    <= 1'b1;
        cnt_lat_hi_r <= hit_cnt_h;
        cnt_buf_r    <= count_r;
      end else if (cnt_lat_hi_r != hit_cnt_h) begin
        cnt_lat_r <= 1'b0;
      end
    end
  end

  // capture channels
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    sync_edge_if               pin_e ();
    logic                      flag_r, irqen_r, lat_r, lat_hi_r, sel, cap_mode, event_hit;
    logic [1:0]                mode_r;
    timer_capture_pkg::edge_sel_t edge_r;
    logic [15:0]               val_r, buf_r;

    pin_sync_edge u_pin_sync (.pclk(pclk), .presetn(presetn), .pin(chan_pin[c]), .e(pin_e));

    assign sel       = (ch_idx == 1'(c));
    assign cap_mode  = !cpwm_r && (mode_r == `MODE_CAPTURE); // RQ6 RQ13
    assign event_hit = cap_mode &&
      ((edge_r == timer_capture_pkg::EDGE_RISE && pin_e.rise) ||
       (edge_r == timer_capture_pkg::EDGE_FALL && pin_e.fall) ||
       (edge_r == timer_capture_pkg::EDGE_BOTH && (pin_e.rise || pin_e.fall))); // RQ20 RQ14

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irqen_r <= 1'b0;
        mode_r  <= `MODE_CAPTURE; // RQ21
        edge_r  <= timer_capture_pkg::EDGE_RELEASED; // RQ21
      end else if (acc_wr && hit_ch_sc && sel) begin
        irqen_r <= pwdata[`CH_IRQEN_BIT];
        mode_r  <= pwdata[`CH_MODE_HI:`CH_MODE_LO]; // RQ13
        edge_r  <= timer_capture_pkg::edge_sel_t'(pwdata[`CH_EDGE_HI:`CH_EDGE_LO]);
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_r <= 1'b0;
      end else if (event_hit) begin
        flag_r <= 1'b1; // RQ17 RQ18
      end else if (acc_wr && hit_ch_sc && sel && pwdata[`CH_FLAG_BIT]) begin
        flag_r <= 1'b0;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        val_r <= `COUNT_ZERO;
      end else if (event_hit) begin
        val_r <= count_r; // RQ14 RQ18
      end else if (!cap_mode && acc_wr && hit_ch_vh && sel) begin
        val_r[15:8] <= pwdata[`BYTE_HI:0]; // RQ15
      end else if (!cap_mode && acc_wr && hit_ch_vl && sel) begin
        val_r[7:0] <= pwdata[`BYTE_HI:0]; // RQ15
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lat_r    <= 1'b0;
        lat_hi_r <= 1'b0;
        buf_r    <= `COUNT_ZERO;
      end else if (acc_wr && hit_ch_sc && sel) begin
        lat_r <= 1'b0; // RQ16
      end else if (rd_go && (hit_ch_vh || hit_ch_vl) && sel && !debug_halt_mode) begin
        if (!lat_r) begin
          lat_r    <= 1'b1; // RQ16
          lat_hi_r <= hit_ch_vh;
          buf_r    <= val_r;
        end else if (lat_hi_r != hit_ch_vh) begin
          lat_r <= 1'b0; // RQ16
        end
      end
    end

    assign ch_flag_w[c]  = flag_r;
    assign ch_irqen_w[c] = irqen_r;
    assign ch_edge_w[c]  = edge_r;
    assign ch_sc_rd[c]   = {flag_r, irqen_r, mode_r, edge_r, 2'b00};
    assign ch_rd_hi[c]   = (lat_r && !debug_halt_mode) ? buf_r[15:8] : val_r[15:8];
    assign ch_rd_lo[c]   = (lat_r && !debug_halt_mode) ? buf_r[7:0] : val_r[7:0];
  end

  // interrupt levels and pin ownership
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_irq_r  <= 1'b0;
      chan_irq_r  <= '0;
      pin_owned_r <= '0;
    end else begin
      wrap_irq_r <= wrap_flag_r && wrap_irq_en_r; // RQ7
      for (int i = 0; i < NCH; i++) begin
        chan_irq_r[i]  <= ch_flag_w[i] && ch_irqen_w[i]; // RQ17
        pin_owned_r[i] <= (ch_edge_w[i] != timer_capture_pkg::EDGE_RELEASED); // RQ20
      end
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign wrap_irq       = wrap_irq_r;
  assign chan_irq       = chan_irq_r;
  assign chan_pin_owned = pin_owned_r;
endmodule : timer_counter_input_capture
